// ==== core/vdp_pkg.sv ====
// package for the voice dac / modulator control block
// assumes a single 125 MHz clock and a plain register port
package vdp_pkg;
    localparam logic [7:0] ADDR_SAMPLE = 8'h0e;
    localparam logic [7:0] ADDR_CONTROL = 8'h13;
    localparam int BIT_PIN_SEL = 0;
    localparam int BIT_DAC_EN = 1;
    localparam int BIT_MOD_EN = 2;
    localparam int BIT_DRV_EN = 3;
    localparam int DRV_LO = 4;
    localparam int DRV_HI = 6;
    localparam int CMD_BIT = 7;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] SAMPLE_RESET = 8'h00;
    localparam logic [7:0] CTRL_MASK_8 = 8'h7f;
    localparam logic [7:0] CTRL_MASK_7 = 8'h07;
    localparam logic [2:0] DRV_OFF = 3'h0;
    localparam logic [7:0] ZERO_BYTE = 8'h00;
    localparam logic [7:0] CNT_TOP_8 = 8'hff;
    localparam logic [7:0] CNT_TOP_7 = 8'h7f;
    localparam logic [2:0] UNIT_SINGLE = 3'h1;
    localparam logic [2:0] UNIT_DOUBLE = 3'h2;
    localparam logic [2:0] UNITS_MAX = 3'h5;
    localparam logic [2:0] DRV_FULL = 3'h7;
endpackage

// ==== core/vdp_voice.sv ====
// voice output control: sample register, control register, modulator
// assumes the cpu register port is synchronous to clk and the width option is static
//
// Design decision made here: the plain strobed port.
module vdp_voice #(
    parameter bit WIDTH_OPTION = 1'b1
) (
    // clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // power mode
    input wire logic sleep_entry,
    input wire logic fast_clk_en,
    // analogue converter
    output logic dac_enable,
    output logic dac_pin_select,
    output logic [7:0] dac_sample,
    // modulated output drivers
    output logic mod_out,
    output logic [2:0] drive_strength
);
    logic [7:0] sample_q, sample_d;
    logic [7:0] ctrl_q, ctrl_d;
    logic [7:0] cmd_q, cmd_d;
    logic [7:0] cnt_q;
    logic [7:0] rdata_q;
    logic mod_q;

    wire is_8bit = WIDTH_OPTION;
    wire wr_sample = reg_wr && (reg_addr == vdp_pkg::ADDR_SAMPLE);
    wire wr_ctrl = reg_wr && (reg_addr == vdp_pkg::ADDR_CONTROL);
    wire rd_sample = reg_rd && (reg_addr == vdp_pkg::ADDR_SAMPLE);
    wire rd_ctrl = reg_rd && (reg_addr == vdp_pkg::ADDR_CONTROL);
    wire cmd_write = !is_8bit && reg_wdata[vdp_pkg::CMD_BIT];
    wire [7:0] ctrl_mask = is_8bit ? vdp_pkg::CTRL_MASK_8 : vdp_pkg::CTRL_MASK_7;

    // 7-bit data words carry no bit 7, so the sample stays in the low bits
    wire [7:0] sample_wval = is_8bit ? reg_wdata : {1'b0, reg_wdata[6:0]};
    assign sample_d = (wr_sample && !cmd_write) ? sample_wval : sample_q;

    // control word as written, with bits outside the layout's ctrl_mask cleared
    wire [7:0] ctrl_w = reg_wdata & ctrl_mask;
    wire mod_en_new = ctrl_w[vdp_pkg::BIT_MOD_EN];
    // driver enable and strength cannot survive a modulator disable
    wire [7:0] ctrl_guard = mod_en_new ? ctrl_w : (ctrl_w & vdp_pkg::CTRL_MASK_7);
    wire [7:0] ctrl_wr_val = wr_ctrl ? ctrl_guard : ctrl_q;
    // sleep wins over a coincident write so outputs really go quiet
    assign ctrl_d = sleep_entry ? (ctrl_q & ~ctrl_mask) : ctrl_wr_val;

    // 7-bit command register holds strength and driver enable
    wire [7:0] cmd_wval = {1'b0, reg_wdata[6:4], reg_wdata[3], 3'h0};
    wire mod_en = ctrl_q[vdp_pkg::BIT_MOD_EN];
    // next-state enable, so the command clears on the same edge as the control bit
    wire mod_en_d = ctrl_d[vdp_pkg::BIT_MOD_EN];
    assign cmd_d = (!is_8bit && (!mod_en_d || sleep_entry)) ? vdp_pkg::ZERO_BYTE :
                   (wr_sample && cmd_write) ? cmd_wval : cmd_q;

    // effective driver settings per layout
    wire drv_en = is_8bit ? ctrl_q[vdp_pkg::BIT_DRV_EN] : cmd_q[vdp_pkg::BIT_DRV_EN];
    wire [2:0] strength = is_8bit ? ctrl_q[vdp_pkg::DRV_HI:vdp_pkg::DRV_LO] :
                          cmd_q[vdp_pkg::DRV_HI:vdp_pkg::DRV_LO];
    // modulator time base: fast clock enable gated by driver enable
    wire mod_tick = fast_clk_en && drv_en && mod_en;
    wire [7:0] cnt_top = is_8bit ? vdp_pkg::CNT_TOP_8 : vdp_pkg::CNT_TOP_7;
    wire [7:0] cnt_next = (cnt_q >= cnt_top) ? vdp_pkg::ZERO_BYTE : cnt_q + 8'h01;
    wire mod_active = mod_en && drv_en && (strength != vdp_pkg::DRV_OFF);
    wire mod_level = mod_active && (cnt_q < sample_q);

    wire [7:0] rd_val = rd_sample ? sample_q :
                        rd_ctrl ? (ctrl_q & ctrl_mask) : vdp_pkg::ZERO_BYTE;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            sample_q <= vdp_pkg::SAMPLE_RESET;
            ctrl_q <= vdp_pkg::CTRL_RESET;
            cmd_q <= vdp_pkg::ZERO_BYTE;
        end else begin
            sample_q <= sample_d;
            ctrl_q <= ctrl_d;
            cmd_q <= cmd_d;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_q <= vdp_pkg::ZERO_BYTE;
        end else if (mod_tick) begin
            cnt_q <= cnt_next;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rdata_q <= vdp_pkg::ZERO_BYTE;
            mod_q <= 1'b0;
            dac_enable <= 1'b0;
            dac_pin_select <= 1'b0;
            dac_sample <= vdp_pkg::SAMPLE_RESET;
            drive_strength <= vdp_pkg::DRV_OFF;
        end else begin
            rdata_q <= rd_val;
            mod_q <= mod_level;
            dac_enable <= ctrl_d[vdp_pkg::BIT_DAC_EN];
            // pin choice only meaningful while the converter runs
            dac_pin_select <= ctrl_d[vdp_pkg::BIT_DAC_EN] && ctrl_d[vdp_pkg::BIT_PIN_SEL];
            dac_sample <= sample_d;
            drive_strength <= mod_active ? strength : vdp_pkg::DRV_OFF;
        end
    end

    assign reg_rdata = rdata_q;
    assign mod_out = mod_q;

    // output driver units: code bit 0 is one single driver, bits 1 and 2 one double each
    logic [2:0] unit_w [3];
    for (genvar gi = 0; gi < 3; gi++) begin : g_unit
        localparam logic [2:0] WEIGHT = (gi == 0) ? vdp_pkg::UNIT_SINGLE : vdp_pkg::UNIT_DOUBLE;
        assign unit_w[gi] = drive_strength[gi] ? WEIGHT : vdp_pkg::DRV_OFF;
    end
    // only read by the checks below; the pad drivers decode the code themselves
    wire [2:0] drv_units = unit_w[0] + unit_w[1] + unit_w[2];

    // duty check helper: counts high decisions over one whole counter period
    // a period only counts as clean if the sample and the enables held throughout
    logic [8:0] duty_hi_q;
    logic duty_clean_q;
    wire period_end = mod_tick && (cnt_q == cnt_top);
    wire [8:0] duty_hi_next = duty_hi_q + {8'h00, mod_level};
    wire duty_keep = duty_clean_q && mod_active && (sample_d == sample_q);
    wire duty_judge = period_end && duty_keep;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            duty_hi_q <= 9'h000;
            duty_clean_q <= 1'b0;
        end else if (period_end) begin
            duty_hi_q <= 9'h000;
            duty_clean_q <= mod_active;
        end else begin
            duty_hi_q <= mod_tick ? duty_hi_next : duty_hi_q;
            duty_clean_q <= duty_keep;
        end
    end

    // assertions
    a_sleep_clears_ctrl: assert property (@(posedge clk) disable iff (!arst_n)
        sleep_entry |=> ((ctrl_q & ctrl_mask) == 8'h00))
        else $error("control not cleared by sleep");
    a_sleep_clears_low: assert property (@(posedge clk) disable iff (!arst_n)
        sleep_entry |=> (ctrl_q[2:0] == 3'h0))
        else $error("low control bits not cleared by sleep");
    a_mod_off_guard: assert property (@(posedge clk) disable iff (!arst_n)
        !ctrl_q[vdp_pkg::BIT_MOD_EN] |-> !drv_en && (strength == 3'h0))
        else $error("driver settings kept with modulator off");
    a_sample_write: assert property (@(posedge clk) disable iff (!arst_n)
        (wr_sample && is_8bit) |=> (dac_sample == $past(reg_wdata)))
        else $error("sample not presented to converter");
    a_cmd_keeps_sample: assert property (@(posedge clk) disable iff (!arst_n)
        (wr_sample && cmd_write) |=> $stable(sample_q))
        else $error("command word changed sample");
    a_ctrl_mask_7: assert property (@(posedge clk) disable iff (!arst_n)
        !is_8bit |-> (ctrl_q[7:3] == 5'h00))
        else $error("unimplemented control bits set");
    a_pin_needs_dac: assert property (@(posedge clk) disable iff (!arst_n)
        dac_pin_select |-> dac_enable)
        else $error("pin select without converter enabled");
    a_duty_follows: assert property (@(posedge clk) disable iff (!arst_n)
        mod_out |-> $past(cnt_q) < $past(sample_q))
        else $error("modulator high with counter not below sample");
    a_counter_gated: assert property (@(posedge clk) disable iff (!arst_n)
        !mod_tick |=> $stable(cnt_q))
        else $error("counter moved without gated clock");
    a_read_ctrl: assert property (@(posedge clk) disable iff (!arst_n)
        rd_ctrl && !wr_ctrl && !sleep_entry |=> reg_rdata == (ctrl_q & ctrl_mask))
        else $error("control read back wrong");
    c_mod_high: cover property (@(posedge clk) disable iff (!arst_n) mod_out);
    c_sleep: cover property (@(posedge clk) disable iff (!arst_n) sleep_entry && ctrl_q != 8'h00);
    c_both_paths: cover property (@(posedge clk) disable iff (!arst_n) mod_out && dac_enable);
    c_full_drive: cover property (@(posedge clk) disable iff (!arst_n) drive_strength == 3'h7);
    c_seven_cmd: cover property (@(posedge clk) disable iff (!arst_n) wr_sample && cmd_write);

    // converter side follows the registers, and the read port returns them
    a_dac_en_match: assert property (@(posedge clk) disable iff (!arst_n)
        dac_enable ==
        ctrl_q[vdp_pkg::BIT_DAC_EN])
        else $error("converter enable differs from control");

    a_sample_mirror: assert property (@(posedge clk) disable iff (!arst_n)
        dac_sample ==
        sample_q)
        else $error("converter sample differs from register");

    a_pin_follows: assert property (@(posedge clk) disable iff (!arst_n)
        dac_pin_select ==
        (ctrl_q[vdp_pkg::BIT_DAC_EN] && ctrl_q[vdp_pkg::BIT_PIN_SEL]))
        else $error("pin select differs from control");

    a_ctrl_keeps_dac: assert property (@(posedge clk) disable iff (!arst_n)
        wr_ctrl |=>
        $stable(dac_sample))
        else $error("control write moved converter sample");

    a_dac_no_strength: assert property (@(posedge clk) disable iff (!arst_n)
        $changed(drive_strength) && !$past(wr_sample) |->
        $stable(dac_sample))
        else $error("strength change moved converter sample");

    a_read_sample: assert property (@(posedge clk) disable iff (!arst_n)
        rd_sample |=>
        reg_rdata == $past(sample_q))
        else $error("sample read back wrong");

    a_read_idle: assert property (@(posedge clk) disable iff (!arst_n)
        !rd_sample && !rd_ctrl |=>
        reg_rdata == vdp_pkg::ZERO_BYTE)
        else $error("read data not zero without a mapped read");

    // control register behaviour
    a_ctrl_write_lands: assert property (@(posedge clk) disable iff (!arst_n)
        wr_ctrl && !sleep_entry && mod_en_new |=>
        ctrl_q == $past(ctrl_w))
        else $error("control write did not land");

    a_ctrl_guard_drop: assert property (@(posedge clk) disable iff (!arst_n)
        wr_ctrl && !sleep_entry && !mod_en_new |=>
        (ctrl_q & ~vdp_pkg::CTRL_MASK_7) == vdp_pkg::ZERO_BYTE)
        else $error("driver bits kept with modulator disabled");

    a_ctrl_bit7_zero: assert property (@(posedge clk) disable iff (!arst_n)
        ctrl_q[vdp_pkg::CMD_BIT] ==
        1'b0)
        else $error("unimplemented control bit 7 set");

    a_drv_en_8: assert property (@(posedge clk) disable iff (!arst_n)
        is_8bit |->
        drv_en == ctrl_q[vdp_pkg::BIT_DRV_EN])
        else $error("driver enable not taken from control");

    // sleep entry
    a_sleep_quiet: assert property (@(posedge clk) disable iff (!arst_n)
        sleep_entry |=> ##1
        (drive_strength == vdp_pkg::DRV_OFF))
        else $error("drivers still on after sleep");

    a_sleep_dac_off: assert property (@(posedge clk) disable iff (!arst_n)
        sleep_entry |=>
        !dac_enable)
        else $error("converter still enabled after sleep");

    a_pin_cleared_sleep: assert property (@(posedge clk) disable iff (!arst_n)
        sleep_entry |=>
        !dac_pin_select)
        else $error("pin select kept after sleep");

    // drive strength
    a_strength_gate: assert property (@(posedge clk) disable iff (!arst_n)
        drive_strength != vdp_pkg::DRV_OFF |->
        $past(mod_active))
        else $error("strength shown while modulator inactive");

    a_strength_value: assert property (@(posedge clk) disable iff (!arst_n)
        $past(mod_active) |->
        drive_strength == $past(strength))
        else $error("strength output differs from setting");

    a_strength_needs_drv: assert property (@(posedge clk) disable iff (!arst_n)
        drive_strength != vdp_pkg::DRV_OFF |->
        $past(drv_en))
        else $error("strength shown without driver enable");

    a_units_limit: assert property (@(posedge clk) disable iff (!arst_n)
        drv_units <=
        vdp_pkg::UNITS_MAX)
        else $error("more than five driver units");

    a_units_full: assert property (@(posedge clk) disable iff (!arst_n)
        drive_strength == vdp_pkg::DRV_FULL |->
        drv_units == vdp_pkg::UNITS_MAX)
        else $error("full code does not give five units");

    // modulator
    a_duty_period: assert property (@(posedge clk) disable iff (!arst_n)
        duty_judge |->
        duty_hi_next == {1'b0, sample_q})
        else $error("high count over a period differs from sample");

    a_mod_needs_active: assert property (@(posedge clk) disable iff (!arst_n)
        mod_out |->
        $past(mod_active))
        else $error("modulator high while inactive");

    a_mod_q_level: assert property (@(posedge clk) disable iff (!arst_n)
        mod_out ==
        $past(mod_level))
        else $error("modulated output lags its decision");

    a_zero_sample_low: assert property (@(posedge clk) disable iff (!arst_n)
        $past(sample_q) == vdp_pkg::ZERO_BYTE |->
        !mod_out)
        else $error("modulator high with zero sample");

    a_cnt_wrap: assert property (@(posedge clk) disable iff (!arst_n)
        period_end |=>
        cnt_q == vdp_pkg::ZERO_BYTE)
        else $error("counter did not wrap at its top");

    a_cnt_step: assert property (@(posedge clk) disable iff (!arst_n)
        mod_tick && !period_end |=>
        cnt_q == $past(cnt_q) + 8'h01)
        else $error("counter did not step by one");

    a_cnt_needs_fast: assert property (@(posedge clk) disable iff (!arst_n)
        $changed(cnt_q) |->
        $past(fast_clk_en) && $past(drv_en))
        else $error("counter moved without fast clock and driver enable");

    // seven-bit layout
    a_seven_sample: assert property (@(posedge clk) disable iff (!arst_n)
        !is_8bit |->
        !sample_q[vdp_pkg::CMD_BIT])
        else $error("seven-bit sample has bit 7 set");

    a_seven_cmd_load: assert property (@(posedge clk) disable iff (!arst_n)
        wr_sample && cmd_write && mod_en_d && !sleep_entry |=>
        cmd_q == $past(cmd_wval))
        else $error("command word not loaded");

    a_seven_cmd_guard: assert property (@(posedge clk) disable iff (!arst_n)
        !is_8bit && cmd_q[vdp_pkg::BIT_DRV_EN] |->
        ctrl_q[vdp_pkg::BIT_MOD_EN])
        else $error("command driver enable without modulator enable");

    a_seven_sleep_cmd: assert property (@(posedge clk) disable iff (!arst_n)
        !is_8bit && sleep_entry |=>
        cmd_q == vdp_pkg::ZERO_BYTE)
        else $error("command word kept after sleep");
endmodule

// ==== test/vdp_speaker_model.sv ====
// far side: speaker drivers, counting modulated high cycles in a window
// assumes mod_out is registered on clk
module vdp_speaker_model (
    // clock
    input wire logic clk,
    // driver input and measuring window
    input wire logic mod_out,
    input wire logic win,
    output int highs
);
    timeunit 1ns;
    timeprecision 1ps;
    // the count restarts outside the window so each measure stands alone
    always @(posedge clk) highs <= !win ? 0 : highs + int'(mod_out);
endmodule

// ==== test/vdp_voice_tb_top.sv ====
// testbench for the voice control block in the 8-bit and seven-bit layouts
// assumes vdp_speaker_model as the far side and a one-cycle read port
module vdp_voice_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0, arst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    logic sleep_entry = 1'b0, fast_clk_en = 1'b0, win = 1'b0;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, dac_sample, v;
    logic dac_enable, dac_pin_select, mod_out;
    logic [2:0] drive_strength;
    int highs, mismatches = 0, total_checks = 0;
    // second instance in the seven-bit layout, sharing the bus and power inputs
    logic [7:0] reg_rdata7, dac_sample7, v7;
    logic dac_enable7, dac_pin_select7, mod_out7;
    logic [2:0] drive_strength7;
    int highs7;
    vdp_voice u_vdp_voice (.clk(clk), .arst_n(arst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .sleep_entry(sleep_entry), .fast_clk_en(fast_clk_en), .dac_enable(dac_enable),
        .dac_pin_select(dac_pin_select), .dac_sample(dac_sample), .mod_out(mod_out),
        .drive_strength(drive_strength));
    vdp_speaker_model u_vdp_speaker_model (.clk(clk), .mod_out(mod_out), .win(win),
        .highs(highs));
    vdp_voice #(.WIDTH_OPTION(1'b0)) u_vdp_voice_7 (.clk(clk), .arst_n(arst_n),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata7), .sleep_entry(sleep_entry), .fast_clk_en(fast_clk_en),
        .dac_enable(dac_enable7), .dac_pin_select(dac_pin_select7),
        .dac_sample(dac_sample7), .mod_out(mod_out7), .drive_strength(drive_strength7));
    vdp_speaker_model u_vdp_speaker_model_7 (.clk(clk), .mod_out(mod_out7), .win(win),
        .highs(highs7));
    initial forever #4 clk = ~clk;
    task automatic check(input string what, input logic [15:0] seen, exp);
        total_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        #1;
    endtask
    // read data stands only in the cycle after the strobe, so it is taken there
    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        v = reg_rdata;
        v7 = reg_rdata7;
    endtask
    task automatic t_reset;
        rd(vdp_pkg::ADDR_SAMPLE); check("sample", v, 8'h00);
        rd(vdp_pkg::ADDR_CONTROL); check("control", v, 8'h00);
        check("control7", v7, 8'h00);
        rd(8'h20); check("unmapped", v, 8'h00);
        $display("test reset done");
    endtask
    task automatic t_dac;
        wr(vdp_pkg::ADDR_SAMPLE, 8'h40); check("dac_sample", dac_sample, 8'h40);
        wr(vdp_pkg::ADDR_CONTROL, 8'h0b);
        check("dac_enable", dac_enable, 1'b1);
        check("pin_select", dac_pin_select, 1'b1);
        rd(vdp_pkg::ADDR_CONTROL); check("control", v, 8'h03);
        $display("test dac done");
    endtask
    task automatic t_pwm;
        wr(vdp_pkg::ADDR_CONTROL, 8'h04);
        wr(vdp_pkg::ADDR_CONTROL, 8'h7c);
        // the strength output follows the stored control one edge later
        @(posedge clk);
        #1;
        check("strength", drive_strength, 3'h7);
        check("pin_select", dac_pin_select, 1'b0);
        check("dac_sample", dac_sample, 8'h40);
        fast_clk_en <= 1'b1;
        repeat (20) @(posedge clk);
        win <= 1'b1;
        repeat (256) @(posedge clk);
        win <= 1'b0;
        #1;
        check("duty", highs[15:0], 16'h0040);
        $display("test pwm done");
    endtask
    task automatic t_sleep;
        @(posedge clk);
        sleep_entry <= 1'b1;
        @(posedge clk);
        sleep_entry <= 1'b0;
        rd(vdp_pkg::ADDR_CONTROL); check("control", v, 8'h00);
        check("strength", drive_strength, 3'h0);
        wr(vdp_pkg::ADDR_CONTROL, 8'h04);
        rd(vdp_pkg::ADDR_CONTROL); check("control", v, 8'h04);
        $display("test sleep done");
    endtask
    task automatic t_seven;
        wr(vdp_pkg::ADDR_SAMPLE, 8'hf8);
        @(posedge clk);
        #1;
        check("strength7", drive_strength7, 3'h7);
        check("sample7", dac_sample7, 8'h40);
        win <= 1'b1;
        repeat (128) @(posedge clk);
        win <= 1'b0;
        #1;
        check("duty7", highs7[15:0], 16'h0040);
        wr(vdp_pkg::ADDR_SAMPLE, 8'h25);
        check("sample7", dac_sample7, 8'h25);
        rd(vdp_pkg::ADDR_CONTROL); check("control7", v7, 8'h04);
        wr(vdp_pkg::ADDR_CONTROL, 8'h03);
        repeat (2) @(posedge clk);
        #1;
        check("strength7", drive_strength7, 3'h0);
        check("pin7", dac_pin_select7, 1'b1);
        @(posedge clk);
        sleep_entry <= 1'b1;
        @(posedge clk);
        sleep_entry <= 1'b0;
        rd(vdp_pkg::ADDR_CONTROL); check("control7", v7, 8'h00);
        check("dac_enable7", dac_enable7, 1'b0);
        $display("test seven done");
    endtask
    task automatic test_done;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial begin
        repeat (12) @(posedge clk);
        arst_n <= 1'b1;
        t_reset();
        t_dac();
        t_pwm();
        t_sleep();
        t_seven();
        test_done();
    end
endmodule
